// file: dioc_pkg.sv
// dedicated i/o control ports: shared constants and carrier types
// assumes one 50 MHz clock standing in for the double-rate processor clock
package dioc_pkg;
  // port addresses on the 8-bit i/o decode
  localparam logic [7:0] DIOC_PS2_SYSCTL = 8'h92;
  localparam logic [7:0] DIOC_CFG_INDEX = 8'hec;
  localparam logic [7:0] DIOC_CFG_DATA = 8'hed;
  localparam logic [7:0] DIOC_QUICK_A20 = 8'hee;
  localparam logic [7:0] DIOC_QUICK_RESTART = 8'hef;
  localparam logic [7:0] DIOC_BUSY_RELEASE = 8'hf0;
  localparam logic [7:0] DIOC_COPROC_RESET = 8'hf1;
  localparam logic [7:0] DIOC_REDUCED_SPEED = 8'hf4;
  localparam logic [7:0] DIOC_FULL_SPEED = 8'hf5;
  localparam logic [7:0] DIOC_CFG_LOCK = 8'hf9;
  localparam logic [7:0] DIOC_CFG_UNLOCK = 8'hfb;
  localparam logic [7:0] DIOC_LOCK_LO = 8'he8;
  localparam logic [7:0] DIOC_LOCK_HI = 8'hef;
  // indexed misc setup register and its fields
  localparam logic [7:0] DIOC_MISC_INDEX = 8'h14;
  localparam int DIOC_SPD_BIT = 7;
  localparam int DIOC_F1D_BIT = 6;
  localparam logic [7:0] DIOC_MISC_RESET = 8'h19;
  localparam logic [7:0] DIOC_MISC_FIXED1 = 8'h18;
  localparam int DIOC_SYS_A20_BIT = 1;
  localparam int DIOC_SYS_RST_BIT = 0;
  localparam logic [7:0] DIOC_ALL_ONES = 8'hff;
  localparam logic [7:0] DIOC_UNDEF_READ = 8'hff;
  // timing in cycles of the double-rate clock
  localparam int DIOC_CLK_MHZ = 50;
  localparam int DIOC_HOT_DELAY_NS = 6720;
  localparam int DIOC_HOT_DELAY_CYC = (DIOC_HOT_DELAY_NS * DIOC_CLK_MHZ + 999) / 1000;
  localparam int DIOC_CPU_RST_CYC = 16;
  localparam int DIOC_NPX_RST_CYC = 40;
  localparam int DIOC_NPX_HOLD_CYC = 50;
  // one i/o cycle from the host, valid for one clock
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dioc_io_req_t;
endpackage

// file: dioc_pulse.sv
// one-shot pulse stretcher: fixed-width pulse after an optional delay
// assumes start is a one-cycle pulse in the CLK domain
`timescale 1ns/1ps
`default_nettype none
module dioc_pulse #(
  parameter int DELAY = 1,
  parameter int WIDTH = 16
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic START,
  output logic BUSY,
  output logic PULSE,
  output logic DONE
);
  localparam int CW = $clog2(DELAY + WIDTH + 1);
  logic [CW-1:0] cnt;
  // counts down delay then width; a start while running restarts it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cnt <= '0;
    end else if (START) begin
      cnt <= CW'(DELAY + WIDTH);
    end else if (cnt != '0) begin
      cnt <= cnt - CW'(1);
    end
  end
  // registered pulse so the pin is glitch free
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PULSE <= 1'b0;
      DONE <= 1'b0;
    end else begin
      PULSE <= !START && cnt != '0 && cnt <= CW'(WIDTH);
      DONE <= !START && cnt == CW'(1);
    end
  end
  assign BUSY = (cnt != '0) || PULSE;
endmodule // dioc_pulse
`default_nettype wire

// file: dioc_ports.sv
// dedicated i/o control ports of the system controller
// assumes host i/o cycles arrive as one-clock strobes synchronous to CLK
// Functional notes
// R1: a byte written to the index port selects the indexed register for data port
// R2: index holds until rewritten; reading it returns the last written value
// R3: reading quick a20 port enables the gate, returns ff; any write disables it
// R4: a20 output is internal gate or keyboard controller a20 enable
// R5: internal a20 gate is disabled after reset
// R6: bit 1 of the system port also controls the a20 gate
// R7: system port bit 1 and quick a20 share one gate state
// R8: quick a20 port responds only while special ports are enabled
// R9: reading the quick restart port resets the processor and returns ff
// R10: quick restart request is ored with keyboard controller reset request
// R11: system port bit 0 set resets cpu after 6.72 us, pulse of 16 cycles
// R12: system port reset bit stays set until rewritten or external reset
// R13: with special ports disabled, quick restart is inactive, other resets remain
// R14: any write to busy release port clears the coprocessor busy flop
// R15: write to coprocessor reset port gives 40-cycle positive reset pulse
// R16: cpu ready held inactive 50 more cycles after coprocessor reset falls
// R17: coprocessor reset port works only while its disable bit is zero
// R18: full speed port selects normal speed, reduced port the divider; reset fast
// R19: speed ports respond only with special ports enabled; reads undefined
// R20: unlock port enables configuration writes, lock port disables them
// R21: while locked, writes to e8h through efh are ignored
// R22: special ports disabled also disables the lock and unlock feature
// R23: misc setup index 14h bit 7 is special ports disable, one disables
// R24: dummy-access ports ignore the data and act on the access itself
`timescale 1ns/1ps
`default_nettype none
module dioc_ports #(
  parameter int NREGS = 256
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire dioc_pkg::dioc_io_req_t IO_REQ,
  output logic [7:0] IO_RDATA,
  output logic IO_HIT,
  input wire logic KBC_A20_ENABLE,
  input wire logic KBC_RESET_REQUEST_N,
  input wire logic COPROC_ERROR_N,
  input wire logic CPU_READY_IN_N,
  output logic ADDRESS_BIT_TWENTY_GATE,
  output logic CPU_RESET_OUT,
  output logic COPROC_RESET_OUT,
  output logic CPU_COPROC_BUSY_N,
  output logic CPU_OPERAND_REQUEST,
  output logic CPU_READY_OUT_N,
  output logic REDUCED_SPEED,
  output logic CONFIG_UNLOCKED,
  output logic [7:0] MISC_SETUP
);
  import dioc_pkg::*;

  logic [7:0] cfg_index;
  logic [7:0] misc_setup_register;
  logic [7:0] cfg_regs [NREGS];
  logic a20_gate;
  logic sys_reset_bit;
  logic config_unlocked;
  logic coproc_busy;
  logic reduced_speed;
  logic special_ports_disable;
  logic coproc_reset_port_disable;
  logic wr_allowed;
  logic hit_quick_a20;
  logic hit_restart;
  logic hit_speed;
  logic hit_lock;
  logic quick_restart_start;
  logic hot_restart_start;
  logic npx_reset_start;
  logic cpu_rst_quick;
  logic cpu_rst_hot;
  logic npx_busy;
  logic npx_done;
  logic [6:0] ready_hold;
  logic [7:0] next_rdata;

  assign special_ports_disable = misc_setup_register[DIOC_SPD_BIT]; // see R23
  assign coproc_reset_port_disable = misc_setup_register[DIOC_F1D_BIT];
  // lock feature collapses when special ports are off
  assign wr_allowed = config_unlocked || special_ports_disable; // see R21 see R22
  assign hit_quick_a20 = IO_REQ.addr == DIOC_QUICK_A20 && !special_ports_disable; // see R8
  assign hit_restart = IO_REQ.addr == DIOC_QUICK_RESTART && !special_ports_disable; // see R13
  assign hit_speed = (IO_REQ.addr == DIOC_REDUCED_SPEED || IO_REQ.addr == DIOC_FULL_SPEED)
    && !special_ports_disable; // see R19
  assign hit_lock = (IO_REQ.addr == DIOC_CFG_LOCK || IO_REQ.addr == DIOC_CFG_UNLOCK)
    && !special_ports_disable; // see R22

  // index pointer, held until rewritten
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cfg_index <= 8'h00;
    end else if (IO_REQ.wr && wr_allowed && IO_REQ.addr == DIOC_CFG_INDEX) begin
      cfg_index <= IO_REQ.wdata; // see R1 see R2
    end
  end

  // indexed registers; misc setup has its own reset value and fixed bits
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      misc_setup_register <= DIOC_MISC_RESET;
    end else if (IO_REQ.wr && wr_allowed && IO_REQ.addr == DIOC_CFG_DATA
        && cfg_index == DIOC_MISC_INDEX) begin
      misc_setup_register <= IO_REQ.wdata | DIOC_MISC_FIXED1; // see R1 see R23
    end
  end

  // other indexed registers are plain storage, no reset needed
  always_ff @(posedge CLK) begin
    if (IO_REQ.wr && wr_allowed && IO_REQ.addr == DIOC_CFG_DATA) begin
      cfg_regs[cfg_index] <= IO_REQ.wdata; // see R1
    end
  end

  // one shared a20 gate for both the quick port and system port bit 1
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      a20_gate <= 1'b0; // see R5
    end else if (IO_REQ.rd && hit_quick_a20) begin
      a20_gate <= 1'b1; // see R3 see R7
    end else if (IO_REQ.wr && wr_allowed && hit_quick_a20) begin
      a20_gate <= 1'b0; // see R3 see R24
    end else if (IO_REQ.wr && IO_REQ.addr == DIOC_PS2_SYSCTL) begin
      a20_gate <= IO_REQ.wdata[DIOC_SYS_A20_BIT]; // see R6 see R7
    end
  end

  // system port reset bit latches; any write with bit 0 set starts the delayed reset
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sys_reset_bit <= 1'b0;
    end else if (IO_REQ.wr && IO_REQ.addr == DIOC_PS2_SYSCTL) begin
      sys_reset_bit <= IO_REQ.wdata[DIOC_SYS_RST_BIT]; // see R12
    end
  end
  // system port stays live even with special ports off
  assign hot_restart_start = IO_REQ.wr && IO_REQ.addr == DIOC_PS2_SYSCTL
    && IO_REQ.wdata[DIOC_SYS_RST_BIT]; // see R11 see R13
  assign quick_restart_start = IO_REQ.rd && hit_restart; // see R9 see R24

  // configuration lock; unlocked out of reset so firmware can set up
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      config_unlocked <= 1'b1;
    end else if (IO_REQ.wr && hit_lock) begin
      config_unlocked <= IO_REQ.addr == DIOC_CFG_UNLOCK; // see R20 see R24
    end
  end

  // speed selection, full speed after reset
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      reduced_speed <= 1'b0; // see R18
    end else if (IO_REQ.wr && hit_speed) begin
      reduced_speed <= IO_REQ.addr == DIOC_REDUCED_SPEED; // see R18 see R19
    end
  end

  // coprocessor busy flop: error sets, release write clears; set wins
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      coproc_busy <= 1'b0;
    end else if (!COPROC_ERROR_N) begin
      coproc_busy <= 1'b1;
    end else if (IO_REQ.wr && IO_REQ.addr == DIOC_BUSY_RELEASE) begin
      coproc_busy <= 1'b0; // see R14 see R24
    end
  end

  assign npx_reset_start = IO_REQ.wr && IO_REQ.addr == DIOC_COPROC_RESET
    && !coproc_reset_port_disable; // see R15 see R17

  // quick restart: pulse starts at once
  dioc_pulse #(.DELAY(0), .WIDTH(DIOC_CPU_RST_CYC)) u_quick (
    .CLK(CLK), .RST_N(RST_N), .START(quick_restart_start),
    .BUSY(), .PULSE(cpu_rst_quick), .DONE());
  // system port restart: delay lets the write cycle finish first
  dioc_pulse #(.DELAY(DIOC_HOT_DELAY_CYC), .WIDTH(DIOC_CPU_RST_CYC)) u_hot (
    .CLK(CLK), .RST_N(RST_N), .START(hot_restart_start),
    .BUSY(), .PULSE(cpu_rst_hot), .DONE()); // see R11
  // coprocessor reset pulse
  dioc_pulse #(.DELAY(0), .WIDTH(DIOC_NPX_RST_CYC)) u_npx (
    .CLK(CLK), .RST_N(RST_N), .START(npx_reset_start),
    .BUSY(npx_busy), .PULSE(COPROC_RESET_OUT), .DONE(npx_done)); // see R15

  // ready hold counter after coprocessor reset falls
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ready_hold <= 7'h00;
    end else if (npx_reset_start) begin
      ready_hold <= 7'h00;
    end else if (npx_done) begin
      ready_hold <= 7'(DIOC_NPX_HOLD_CYC); // see R16
    end else if (ready_hold != 7'h00) begin
      ready_hold <= ready_hold - 7'h01;
    end
  end

  // outputs
  assign ADDRESS_BIT_TWENTY_GATE = a20_gate || KBC_A20_ENABLE; // see R4
  assign CPU_RESET_OUT = cpu_rst_quick || cpu_rst_hot || !KBC_RESET_REQUEST_N; // see R10
  assign CPU_COPROC_BUSY_N = !coproc_busy;
  assign CPU_OPERAND_REQUEST = coproc_busy;
  assign CPU_READY_OUT_N = CPU_READY_IN_N || npx_busy || ready_hold != 7'h00; // see R16
  assign REDUCED_SPEED = reduced_speed;
  assign CONFIG_UNLOCKED = config_unlocked;
  assign MISC_SETUP = misc_setup_register;

  // read mux
  always_comb begin
    next_rdata = DIOC_UNDEF_READ;
    IO_HIT = 1'b1;
    if (IO_REQ.addr == DIOC_CFG_INDEX) begin
      next_rdata = cfg_index; // see R2
    end else if (IO_REQ.addr == DIOC_CFG_DATA) begin
      next_rdata = cfg_index == DIOC_MISC_INDEX ? misc_setup_register : cfg_regs[cfg_index];
    end else if (IO_REQ.addr == DIOC_PS2_SYSCTL) begin
      next_rdata = {6'h3f, a20_gate, sys_reset_bit}; // see R7
    end else if (hit_quick_a20 || hit_restart) begin
      next_rdata = DIOC_ALL_ONES; // see R3 see R9
    end else if (hit_speed || hit_lock) begin
      next_rdata = DIOC_UNDEF_READ; // see R19 see R20
    end else begin
      IO_HIT = 1'b0;
    end
  end

  // read data registered, valid the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      IO_RDATA <= 8'h00;
    end else if (IO_REQ.rd) begin
      IO_RDATA <= next_rdata;
    end
  end

  // named steps; a second strobe right behind the first restarts a one-shot
  sequence npx_pulse_s;
    COPROC_RESET_OUT [*8];
  endsequence
  sequence npx_go_s;
    npx_reset_start ##1 !npx_reset_start;
  endsequence
  sequence quick_go_s;
    quick_restart_start ##1 !quick_restart_start;
  endsequence

  // coprocessor reset pulse and the ready hold behind it
  npx_disable_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R17
    IO_REQ.wr && IO_REQ.addr == DIOC_COPROC_RESET && coproc_reset_port_disable && !npx_busy
    |=> !COPROC_RESET_OUT) else $error("coprocessor reset despite disable");
  npx_go_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R15
    npx_go_s |=> COPROC_RESET_OUT) else $error("coprocessor reset did not start");
  npx_pulse_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R15
    $rose(COPROC_RESET_OUT) |-> npx_pulse_s) else $error("coprocessor reset too short");
  npx_ready_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R16
    $fell(COPROC_RESET_OUT) && !npx_reset_start |-> CPU_READY_OUT_N [*8])
    else $error("ready released early");
  npx_hold_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R16
    npx_reset_start |=> CPU_READY_OUT_N) else $error("ready not held during reset");
  ready_pass_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R16
    CPU_READY_IN_N |-> CPU_READY_OUT_N) else $error("ready input not passed through");

  // shared a20 gate; the quick port only while special ports are on
  a20_read_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R3
    IO_REQ.rd && hit_quick_a20 |=> ADDRESS_BIT_TWENTY_GATE && IO_RDATA == DIOC_ALL_ONES)
    else $error("quick a20 read failed");
  a20_or_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R4
    KBC_A20_ENABLE |-> ADDRESS_BIT_TWENTY_GATE) else $error("a20 not ored");
  a20_off_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R8
    IO_REQ.rd && IO_REQ.addr == DIOC_QUICK_A20 && special_ports_disable |=> $stable(a20_gate))
    else $error("quick a20 read acted while disabled");
  sysport_set_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R6
    IO_REQ.wr && IO_REQ.addr == DIOC_PS2_SYSCTL && IO_REQ.wdata[DIOC_SYS_A20_BIT] |=> a20_gate)
    else $error("system port did not open a20");
  sysport_clear_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R6
    IO_REQ.wr && IO_REQ.addr == DIOC_PS2_SYSCTL && !IO_REQ.wdata[DIOC_SYS_A20_BIT] |=> !a20_gate)
    else $error("system port did not close a20");
  sysport_read_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R7
    IO_REQ.rd && IO_REQ.addr == DIOC_PS2_SYSCTL |=> IO_RDATA[DIOC_SYS_A20_BIT] == $past(a20_gate))
    else $error("system port a20 bit differs from gate");

  // index pointer, indexed data and the configuration lock
  index_hold_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R1
    IO_REQ.wr && wr_allowed && IO_REQ.addr == DIOC_CFG_INDEX |=> cfg_index == $past(IO_REQ.wdata))
    else $error("index not stored");
  index_keep_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R2
    !(IO_REQ.wr && IO_REQ.addr == DIOC_CFG_INDEX) |=> $stable(cfg_index))
    else $error("index changed without a write");
  misc_write_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R23
    IO_REQ.wr && wr_allowed && IO_REQ.addr == DIOC_CFG_DATA && cfg_index == DIOC_MISC_INDEX
    |=> misc_setup_register == ($past(IO_REQ.wdata) | DIOC_MISC_FIXED1))
    else $error("misc setup not written");
  data_read_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R1
    IO_REQ.rd && IO_REQ.addr == DIOC_CFG_DATA && cfg_index == DIOC_MISC_INDEX
    |=> IO_RDATA == $past(misc_setup_register)) else $error("indexed read wrong");
  lock_ignore_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R21
    IO_REQ.wr && !wr_allowed && IO_REQ.addr == DIOC_CFG_INDEX |=> $stable(cfg_index))
    else $error("locked write took effect");
  lock_set_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R20
    IO_REQ.wr && IO_REQ.addr == DIOC_CFG_LOCK && !special_ports_disable |=> !CONFIG_UNLOCKED)
    else $error("lock port did not lock");
  lock_clear_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R20
    IO_REQ.wr && IO_REQ.addr == DIOC_CFG_UNLOCK && !special_ports_disable |=> CONFIG_UNLOCKED)
    else $error("unlock port did not unlock");
  lock_off_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R22
    IO_REQ.wr && (IO_REQ.addr == DIOC_CFG_LOCK || IO_REQ.addr == DIOC_CFG_UNLOCK)
    && special_ports_disable |=> $stable(CONFIG_UNLOCKED))
    else $error("lock port acted while disabled");

  // processor reset paths
  restart_off_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R13
    IO_REQ.rd && IO_REQ.addr == DIOC_QUICK_RESTART && special_ports_disable
    && !CPU_RESET_OUT && KBC_RESET_REQUEST_N && !hot_restart_start |=> !cpu_rst_quick)
    else $error("quick restart while disabled");
  quick_start_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R9
    quick_go_s |=> cpu_rst_quick) else $error("quick restart did not start");
  hot_delay_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R11
    hot_restart_start && !cpu_rst_hot |=> !cpu_rst_hot [*8])
    else $error("hot reset without delay");
  reset_bit_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R12
    !(IO_REQ.wr && IO_REQ.addr == DIOC_PS2_SYSCTL) |=> $stable(sys_reset_bit))
    else $error("system reset bit changed without a write");
  kbc_reset_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R10
    !KBC_RESET_REQUEST_N || cpu_rst_quick |-> CPU_RESET_OUT) else $error("reset requests not ored");

  // coprocessor busy flop, set wins over release
  busy_set_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R14
    !COPROC_ERROR_N |=> !CPU_COPROC_BUSY_N && CPU_OPERAND_REQUEST) else $error("busy flop not set");
  busy_clear_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R14
    IO_REQ.wr && IO_REQ.addr == DIOC_BUSY_RELEASE && COPROC_ERROR_N |=> CPU_COPROC_BUSY_N && !CPU_OPERAND_REQUEST)
    else $error("busy flop not released");

  // speed ports
  speed_slow_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R18
    IO_REQ.wr && IO_REQ.addr == DIOC_REDUCED_SPEED && !special_ports_disable |=> REDUCED_SPEED)
    else $error("reduced speed not selected");
  speed_full_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R18
    IO_REQ.wr && IO_REQ.addr == DIOC_FULL_SPEED && !special_ports_disable |=> !REDUCED_SPEED)
    else $error("full speed not selected");
  speed_off_a: assert property (@(posedge CLK) disable iff (!RST_N) // see R19
    IO_REQ.wr && (IO_REQ.addr == DIOC_REDUCED_SPEED || IO_REQ.addr == DIOC_FULL_SPEED) && special_ports_disable
    |=> $stable(REDUCED_SPEED)) else $error("speed port acted while disabled");
endmodule // dioc_ports
`default_nettype wire

// file: dioc_host.sv
// host i/o master model: one-clock read and write strobes
// assumes the block samples IO_REQ on the rising edge of CLK
`timescale 1ns/1ps
`default_nettype none
module dioc_host (
  input wire logic CLK,
  input wire logic [7:0] IO_RDATA,
  output var dioc_pkg::dioc_io_req_t IO_REQ
);
  import dioc_pkg::*;
  initial IO_REQ = '0;
  // write strobe held across exactly one rising edge
  task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    IO_REQ = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge CLK);
    IO_REQ.wr = 1'b0;
    IO_REQ.wdata = ~d; // released data must not look valid
  endtask
  // read strobe; data taken once the registered answer has landed
  task automatic io_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge CLK);
    IO_REQ = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge CLK);
    IO_REQ.rd = 1'b0;
    @(negedge CLK);
    d = IO_RDATA;
  endtask
endmodule // dioc_host
`default_nettype wire

// file: tb.sv
// self-checking bench for the dedicated i/o control ports
// assumes dioc_host drives every host i/o cycle
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dioc_pkg::*;
  logic CLK = 1'b0, RST_N = 1'b0, KBC_A20_ENABLE = 1'b0, KBC_RESET_REQUEST_N = 1'b1;
  logic COPROC_ERROR_N = 1'b1, CPU_READY_IN_N = 1'b0;
  logic [7:0] IO_RDATA, MISC_SETUP, rd;
  logic IO_HIT, ADDRESS_BIT_TWENTY_GATE, CPU_RESET_OUT, COPROC_RESET_OUT, CPU_COPROC_BUSY_N;
  logic CPU_OPERAND_REQUEST, CPU_READY_OUT_N, REDUCED_SPEED, CONFIG_UNLOCKED;
  dioc_io_req_t IO_REQ;
  int n_fail = 0, n_compared = 0, cyc = 0, f0, w0, f1, w1;
  always #10 CLK = ~CLK;
  dioc_host u_dioc_host (.CLK(CLK), .IO_RDATA(IO_RDATA), .IO_REQ(IO_REQ));
  dioc_ports u_dioc_ports (.CLK(CLK), .RST_N(RST_N), .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA), .IO_HIT(IO_HIT),
    .KBC_A20_ENABLE(KBC_A20_ENABLE), .KBC_RESET_REQUEST_N(KBC_RESET_REQUEST_N), .COPROC_ERROR_N(COPROC_ERROR_N),
    .CPU_READY_IN_N(CPU_READY_IN_N), .ADDRESS_BIT_TWENTY_GATE(ADDRESS_BIT_TWENTY_GATE),
    .CPU_RESET_OUT(CPU_RESET_OUT), .COPROC_RESET_OUT(COPROC_RESET_OUT), .CPU_COPROC_BUSY_N(CPU_COPROC_BUSY_N),
    .CPU_OPERAND_REQUEST(CPU_OPERAND_REQUEST), .CPU_READY_OUT_N(CPU_READY_OUT_N),
    .REDUCED_SPEED(REDUCED_SPEED), .CONFIG_UNLOCKED(CONFIG_UNLOCKED), .MISC_SETUP(MISC_SETUP));
  // one compare, reported at once on mismatch
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // first high cycle and high count of one pulse output over a window
  task automatic measure(input int which, input int window, output int first, output int width);
    logic s;
    first = -1;
    width = 0;
    for (int i = 0; i < window; i++) begin
      @(negedge CLK);
      case (which)
        0: s = CPU_RESET_OUT;
        1: s = COPROC_RESET_OUT;
        default: s = CPU_READY_OUT_N;
      endcase
      if (s === 1'b1) begin
        if (first < 0) first = i;
        width++;
      end
    end
  endtask
  task automatic test_reset_state;
    check(MISC_SETUP, 8'h19);
    check({REDUCED_SPEED, CONFIG_UNLOCKED, ADDRESS_BIT_TWENTY_GATE}, 8'h02);
    KBC_A20_ENABLE = 1'b1;
    #1 check(ADDRESS_BIT_TWENTY_GATE, 8'h01);
    KBC_A20_ENABLE = 1'b0;
    $display("reset state done");
  endtask
  task automatic test_index;
    u_dioc_host.io_wr(DIOC_CFG_INDEX, 8'h20);
    u_dioc_host.io_wr(DIOC_CFG_DATA, 8'h5a);
    u_dioc_host.io_rd(DIOC_CFG_DATA, rd);
    check(rd, 8'h5a);
    u_dioc_host.io_rd(DIOC_CFG_INDEX, rd);
    check(rd, 8'h20);
    $display("index window done");
  endtask
  task automatic test_a20;
    u_dioc_host.io_rd(DIOC_QUICK_A20, rd);
    check(rd, 8'hff);
    check(IO_HIT, 8'h01);
    check(ADDRESS_BIT_TWENTY_GATE, 8'h01);
    u_dioc_host.io_rd(DIOC_PS2_SYSCTL, rd);
    check(rd[1], 8'h01);
    u_dioc_host.io_wr(DIOC_QUICK_A20, 8'h5a);
    check(ADDRESS_BIT_TWENTY_GATE, 8'h00);
    u_dioc_host.io_wr(DIOC_PS2_SYSCTL, 8'h02);
    check(ADDRESS_BIT_TWENTY_GATE, 8'h01);
    u_dioc_host.io_wr(DIOC_PS2_SYSCTL, 8'h00);
    check(ADDRESS_BIT_TWENTY_GATE, 8'h00);
    $display("a20 gate done");
  endtask
  task automatic test_lock;
    u_dioc_host.io_wr(DIOC_CFG_LOCK, 8'h00);
    check(CONFIG_UNLOCKED, 8'h00);
    u_dioc_host.io_wr(DIOC_CFG_INDEX, 8'h33);
    u_dioc_host.io_rd(DIOC_CFG_INDEX, rd);
    check(rd, 8'h20);
    u_dioc_host.io_rd(DIOC_CFG_LOCK, rd);
    check(rd, DIOC_UNDEF_READ);
    u_dioc_host.io_wr(DIOC_CFG_UNLOCK, 8'h00);
    check(CONFIG_UNLOCKED, 8'h01);
    $display("config lock done");
  endtask
  task automatic test_cpu_reset;
    // measure alongside the read so the first pulse cycle is not missed
    fork
      u_dioc_host.io_rd(DIOC_QUICK_RESTART, rd);
      measure(0, 40, f0, w0);
    join
    check(rd, 8'hff);
    check(w0, 8'd16);
    u_dioc_host.io_wr(DIOC_PS2_SYSCTL, 8'h03);
    measure(0, 400, f0, w0);
    check(f0 >= 335, 8'h01);
    check(w0, 8'd16);
    u_dioc_host.io_rd(DIOC_PS2_SYSCTL, rd);
    check(rd[1:0], 8'h03);
    u_dioc_host.io_wr(DIOC_PS2_SYSCTL, 8'h00);
    KBC_RESET_REQUEST_N = 1'b0;
    #1 check(CPU_RESET_OUT, 8'h01);
    KBC_RESET_REQUEST_N = 1'b1;
    $display("cpu reset done");
  endtask
  task automatic test_coproc;
    @(negedge CLK) COPROC_ERROR_N = 1'b0;
    @(negedge CLK) COPROC_ERROR_N = 1'b1;
    @(negedge CLK) check({CPU_COPROC_BUSY_N, CPU_OPERAND_REQUEST}, 8'h01);
    u_dioc_host.io_wr(DIOC_BUSY_RELEASE, 8'h00);
    check({CPU_COPROC_BUSY_N, CPU_OPERAND_REQUEST}, 8'h02);
    u_dioc_host.io_wr(DIOC_COPROC_RESET, 8'h00);
    fork
      measure(1, 120, f1, w1);
      measure(2, 120, f0, w0);
    join
    check(w1, 8'd40);
    check(w0 - w1 - f1, 8'd50);
    CPU_READY_IN_N = 1'b1;
    #1 check(CPU_READY_OUT_N, 8'h01);
    CPU_READY_IN_N = 1'b0;
    $display("coprocessor done");
  endtask
  task automatic test_speed;
    u_dioc_host.io_wr(DIOC_REDUCED_SPEED, 8'h00);
    check(REDUCED_SPEED, 8'h01);
    u_dioc_host.io_wr(DIOC_FULL_SPEED, 8'hff);
    check(REDUCED_SPEED, 8'h00);
    $display("speed done");
  endtask
  task automatic test_disabled;
    u_dioc_host.io_wr(DIOC_CFG_INDEX, DIOC_MISC_INDEX);
    u_dioc_host.io_wr(DIOC_CFG_DATA, 8'hd9);
    check(MISC_SETUP, 8'hd9);
    u_dioc_host.io_rd(DIOC_CFG_DATA, rd);
    check(rd, 8'hd9);
    u_dioc_host.io_rd(DIOC_QUICK_RESTART, rd);
    measure(0, 30, f0, w0);
    check(w0, 8'd0);
    u_dioc_host.io_rd(DIOC_QUICK_A20, rd);
    check(ADDRESS_BIT_TWENTY_GATE, 8'h00);
    check(IO_HIT, 8'h00);
    u_dioc_host.io_wr(DIOC_REDUCED_SPEED, 8'h00);
    check(REDUCED_SPEED, 8'h00);
    u_dioc_host.io_wr(DIOC_CFG_LOCK, 8'h00);
    check(CONFIG_UNLOCKED, 8'h01);
    u_dioc_host.io_wr(DIOC_COPROC_RESET, 8'h00);
    measure(1, 50, f1, w1);
    check(w1, 8'd0);
    $display("special ports disabled done");
  endtask
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, well above the fewer than a thousand cycles the tests need
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 8000) begin
      n_fail++;
      $display("unexpected at %0t: run did not finish", $time);
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(negedge CLK);
    RST_N = 1'b1;
    @(negedge CLK);
    test_reset_state();
    test_index();
    test_a20();
    test_lock();
    test_cpu_reset();
    test_coproc();
    test_speed();
    test_disabled();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
